// [include/sfid_defs.vh]
// constants of the serial flash instruction decoder
`ifndef SFID_DEFS_VH
`define SFID_DEFS_VH
// ----
// opcodes
// ----
`define SFID_OP_READ 8'h03
`define SFID_OP_FAST_READ 8'h0B
`define SFID_OP_ERASE_4K 8'h20
`define SFID_OP_ERASE_32K 8'h52
`define SFID_OP_ERASE_64K 8'hD8
`define SFID_OP_CHIP_ERASE_A 8'h60
`define SFID_OP_CHIP_ERASE_B 8'hC7
`define SFID_OP_BYTE_PROG 8'h02
`define SFID_OP_AUTO_INC_PROG 8'hAD
`define SFID_OP_STATUS_READ 8'h05
`define SFID_OP_STATUS_WRITE_EN 8'h50
`define SFID_OP_STATUS_WRITE 8'h01
`define SFID_OP_WRITE_ENABLE 8'h06
`define SFID_OP_WRITE_DISABLE 8'h04
`define SFID_OP_ID_READ_A 8'h90
`define SFID_OP_ID_READ_B 8'hAB
`define SFID_OP_BUSY_ON 8'h70
`define SFID_OP_BUSY_OFF 8'h80
// ----
// geometry
// ----
`define SFID_AW 21
`define SFID_ADDR_BYTES 3
`define SFID_BYTE_BITS 8
`define SFID_FIFO_DEPTH 16
`define SFID_FIFO_PTR_W 4
`define SFID_MASK_4K 24'h000FFF
`define SFID_MASK_32K 24'h007FFF
`define SFID_MASK_64K 24'h00FFFF
// ----
// erase kinds
// ----
`define SFID_ERASE_SECTOR 2'h0
`define SFID_ERASE_BLK32 2'h1
`define SFID_ERASE_BLK64 2'h2
`define SFID_ERASE_CHIP 2'h3
// ----
// identity bytes, arbitrary values
// ----
`define SFID_MAN_ID 8'h5A
`define SFID_DEV_ID 8'hA5
`endif

// [logic/sfid_fifo.v]
// program data fifo with registered read data
`timescale 1ns/1ns
`default_nettype none
`include "sfid_defs.vh"
module sfid_fifo #(
   parameter W = 29,
   parameter DEPTH = `SFID_FIFO_DEPTH,
   parameter PW = `SFID_FIFO_PTR_W
) (
   input wire mclk,
   input wire sys_rst,
   input wire in_valid,
   output wire in_ready,
   input wire [W-1:0] in_data,
   output reg out_valid_r,
   input wire out_ready,
   output reg [W-1:0] out_data_r
);
   reg [W-1:0] mem [0:DEPTH-1];
   reg [PW-1:0] wp_r;
   reg [PW-1:0] rp_r;
   reg [PW:0] cnt_r;
   wire push;
   wire pop;
   wire [PW:0] depth_w;
   assign depth_w = DEPTH[PW:0];
   assign in_ready = (cnt_r != depth_w);
   assign push = in_valid & in_ready;
   assign pop = (cnt_r != {(PW+1){1'b0}}) & (~out_valid_r | out_ready);
   // ----
   // storage
   // ----
   always @(posedge mclk)
   begin
      if (push)
      begin
         mem[wp_r] <= in_data;
      end
   end
   // ----
   // pointers and output stage
   // ----
   always @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         wp_r <= {PW{1'b0}};
         rp_r <= {PW{1'b0}};
         cnt_r <= {(PW+1){1'b0}};
         out_valid_r <= 1'b0;
         out_data_r <= {W{1'b0}};
      end
      else
      begin
         if (push)
         begin
            wp_r <= wp_r + 1'b1;
         end
         if (pop)
         begin
            out_data_r <= mem[rp_r];
            rp_r <= rp_r + 1'b1;
            out_valid_r <= 1'b1;
         end
         else if (out_ready)
         begin
            out_valid_r <= 1'b0;
         end
         if (push & ~pop)
         begin
            cnt_r <= cnt_r + 1'b1;
         end
         else if (pop & ~push)
         begin
            cnt_r <= cnt_r - 1'b1;
         end
      end
   end
endmodule // sfid_fifo
`default_nettype wire

// [logic/sfid_decoder.v]
// serial flash instruction decoder, sampled on the system clock
// How it works
// RULE_01 - bytes are eight bits, msb first
// RULE_02 - host sends write enable before writes
// RULE_03 - cs fall starts, bits taken on rise
// RULE_04 - host raises cs to execute command
// RULE_05 - early cs rise aborts to standby
// RULE_06 - read 03h, three address bytes
// RULE_07 - fast read 0bh, plus one dummy
// RULE_08 - read address increments and wraps
// RULE_09 - read data runs until cs rises
// RULE_10 - sector erase 20h, bits above 11
// RULE_11 - 32k erase 52h, bits above 14
// RULE_12 - 64k erase d8h, bits above 15
// RULE_13 - chip erase 60h or c7h
// RULE_14 - byte program 02h, address, one byte
// RULE_15 - protected byte program silently ignored
// RULE_16 - host programs only erased locations
// RULE_17 - host holds cs low whole program
// RULE_18 - adh word program, even then odd
// RULE_19 - status byte repeats until cs rises
// RULE_20 - id read, address bit zero selects
// RULE_21 - 70h puts busy on output pin; here only while aai_r is set
// RULE_22 - 80h removes busy from output pin
// RULE_23 - upper address bits are ignored
// RULE_24 - write enable latch clearing events
// RULE_25 - unknown or unenabled commands ignored
`timescale 1ns/1ns
`default_nettype none
`include "sfid_defs.vh"
module sfid_decoder #(
   parameter AW = `SFID_AW,
   parameter FIFO_DEPTH = `SFID_FIFO_DEPTH,
   parameter [7:0] MAN_ID = `SFID_MAN_ID,
   parameter [7:0] DEV_ID = `SFID_DEV_ID
) (
   input wire mclk,
   input wire sys_rst,
   input wire sck,
   input wire cs_n,
   input wire si,
   output wire so_o,
   output wire so_oe,
   input wire busy_in,
   input wire [7:0] status_in,
   input wire wp_en,
   input wire [AW-1:0] wp_base,
   output reg mem_rd_en_r,
   output reg [AW-1:0] mem_rd_addr_r,
   input wire [7:0] mem_rd_data,
   output reg erase_req_r,
   output reg [1:0] erase_kind_r,
   output reg [AW-1:0] erase_addr_r,
   output reg stat_wr_req_r,
   output reg [7:0] stat_wr_data_r,
   output wire prog_valid,
   input wire prog_ready,
   output wire [AW-1:0] prog_addr,
   output wire [7:0] prog_data,
   output reg wel_r,
   output reg aai_r
);
   localparam ST_IDLE = 3'd0;
   localparam ST_ADDR = 3'd1;
   localparam ST_DUMMY = 3'd2;
   localparam ST_DIN = 3'd3;
   localparam ST_OUT = 3'd4;
   localparam ST_DONE = 3'd5;
   localparam ST_IGN = 3'd6;
   reg sck_m_r, sck_s_r, sck_p_r;
   reg cs_m_r, cs_s_r, cs_p_r;
   reg si_m_r, si_s_r;
   reg [2:0] state_r;
   reg [2:0] bitcnt_r;
   reg [1:0] bytecnt_r;
   reg [1:0] need_r;
   reg [6:0] sr_in_r;
   reg [15:0] addr_sh_r;
   reg [7:0] cmd_r;
   reg [AW-1:0] addr_r;
   reg [7:0] d0_r;
   reg [7:0] d1_r;
   reg fetch_r;
   reg ld_r;
   reg [7:0] tx_load_r;
   reg [7:0] tx_sr_r;
   reg so_r;
   reg bsy_en_r;
   reg sw_en_r;
   reg [1:0] pend_cnt_r;
   reg [AW-1:0] pend_addr_r;
   reg [7:0] pend_b0_r;
   reg [7:0] pend_b1_r;
   wire sck_rise, sck_fall, cs_fall, cs_rise, active, byte_done;
   wire [7:0] rx_byte;
   wire [23:0] addr24;
   wire [23:0] m4k, m32k, m64k;
   wire [AW-1:0] aai_base, aai_next;
   wire busy_mode, in_ready, wr_ok, prot_here;
   wire [7:0] status_byte;
   assign m4k = `SFID_MASK_4K;
   assign m32k = `SFID_MASK_32K;
   assign m64k = `SFID_MASK_64K;
   // ----
   // pin sampling and edges
   // ----
   always @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         sck_m_r <= 1'b0;
         sck_s_r <= 1'b0;
         sck_p_r <= 1'b0;
         cs_m_r <= 1'b1;
         cs_s_r <= 1'b1;
         cs_p_r <= 1'b1;
         si_m_r <= 1'b0;
         si_s_r <= 1'b0;
      end
      else
      begin
         sck_m_r <= sck;
         sck_s_r <= sck_m_r;
         sck_p_r <= sck_s_r;
         cs_m_r <= cs_n;
         cs_s_r <= cs_m_r;
         cs_p_r <= cs_s_r;
         si_m_r <= si;
         si_s_r <= si_m_r;
      end
   end
   assign active = ~cs_s_r;
   // RULE_03 cs edge detect
   assign cs_fall = ~cs_s_r & cs_p_r;
   assign cs_rise = cs_s_r & ~cs_p_r;
   // RULE_03 sample on rise
   assign sck_rise = active & ~cs_fall & sck_s_r & ~sck_p_r;
   assign sck_fall = active & ~sck_s_r & sck_p_r;
   // RULE_01 eight bits msb first
   assign byte_done = sck_rise & (bitcnt_r == 3'd7);
   assign rx_byte = {sr_in_r, si_s_r};
   assign addr24 = {addr_sh_r, rx_byte};
   // ----
   // write checks
   // ----
   // RULE_15 protected region check
   assign prot_here = wp_en & (addr_r >= wp_base);
   assign aai_base = {addr_r[AW-1:1], 1'b0};
   assign aai_next = aai_base + 2'd2;
   assign wr_ok = (pend_cnt_r == 2'd0);
   assign status_byte = {status_in[7], aai_r, status_in[5:2], wel_r, busy_in};
   // RULE_21 busy shown on output
   assign busy_mode = bsy_en_r & aai_r;
   assign so_oe = active & ((state_r == ST_OUT) | busy_mode);
   assign so_o = (state_r == ST_OUT) ? so_r : ~busy_in;
   // ----
   // program data queue
   // ----
   sfid_fifo #(
      .W(AW + 8),
      .DEPTH(FIFO_DEPTH),
      .PW(`SFID_FIFO_PTR_W)
   ) u_fifo (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .in_valid(pend_cnt_r != 2'd0),
      .in_ready(in_ready),
      .in_data({pend_addr_r, (pend_cnt_r == 2'd2) ? pend_b0_r : pend_b1_r}),
      .out_valid_r(prog_valid),
      .out_ready(prog_ready),
      .out_data_r({prog_addr, prog_data})
   );
   // ----
   // decoder
   // ----
   always @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         state_r <= ST_IDLE;
         bitcnt_r <= 3'd0;
         bytecnt_r <= 2'd0;
         need_r <= 2'd0;
         sr_in_r <= 7'h00;
         addr_sh_r <= 16'h0000;
         cmd_r <= 8'h00;
         addr_r <= {AW{1'b0}};
         d0_r <= 8'h00;
         d1_r <= 8'h00;
         fetch_r <= 1'b0;
         ld_r <= 1'b0;
         tx_load_r <= 8'h00;
         tx_sr_r <= 8'h00;
         so_r <= 1'b0;
         bsy_en_r <= 1'b0;
         sw_en_r <= 1'b0;
         wel_r <= 1'b0;
         aai_r <= 1'b0;
         pend_cnt_r <= 2'd0;
         pend_addr_r <= {AW{1'b0}};
         pend_b0_r <= 8'h00;
         pend_b1_r <= 8'h00;
         mem_rd_en_r <= 1'b0;
         mem_rd_addr_r <= {AW{1'b0}};
         erase_req_r <= 1'b0;
         erase_kind_r <= 2'h0;
         erase_addr_r <= {AW{1'b0}};
         stat_wr_req_r <= 1'b0;
         stat_wr_data_r <= 8'h00;
      end
      else
      begin
         mem_rd_en_r <= 1'b0;
         erase_req_r <= 1'b0;
         stat_wr_req_r <= 1'b0;
         fetch_r <= 1'b0;
         if (pend_cnt_r != 2'd0 && in_ready)
         begin
            pend_cnt_r <= pend_cnt_r - 1'b1;
            pend_addr_r <= pend_addr_r + 1'b1;
         end
         // RULE_08 increment after byte
         if (fetch_r)
         begin
            ld_r <= 1'b1;
            if (cmd_r == `SFID_OP_STATUS_READ)
            begin
               tx_load_r <= status_byte;
            end
            // RULE_20 bit zero selects id
            else if (cmd_r == `SFID_OP_ID_READ_A || cmd_r == `SFID_OP_ID_READ_B)
            begin
               tx_load_r <= addr_r[0] ? DEV_ID : MAN_ID;
            end
            else
            begin
               tx_load_r <= mem_rd_data;
               addr_r <= addr_r + 1'b1;
            end
         end
         // RULE_09 shift out on fall
         if (sck_fall && state_r == ST_OUT)
         begin
            if (ld_r)
            begin
               so_r <= tx_load_r[7];
               tx_sr_r <= {tx_load_r[6:0], 1'b0};
               ld_r <= 1'b0;
            end
            else
            begin
               so_r <= tx_sr_r[7];
               tx_sr_r <= {tx_sr_r[6:0], 1'b0};
            end
         end
         if (sck_rise)
         begin
            sr_in_r <= rx_byte[6:0];
            bitcnt_r <= bitcnt_r + 1'b1;
         end
         if (cs_fall)
         begin
            state_r <= ST_IDLE;
            bitcnt_r <= 3'd0;
            ld_r <= 1'b0;
         end
         else if (cs_rise)
         begin
            // RULE_05 abort unless complete
            state_r <= ST_IDLE;
            if (state_r == ST_DONE)
            begin
               // RULE_04 execute on cs rise
               case (cmd_r)
                  `SFID_OP_WRITE_ENABLE:
                  begin
                     wel_r <= 1'b1;
                  end
                  // RULE_24 disable clears latch
                  `SFID_OP_WRITE_DISABLE:
                  begin
                     wel_r <= 1'b0;
                     aai_r <= 1'b0;
                  end
                  `SFID_OP_STATUS_WRITE_EN:
                  begin
                     sw_en_r <= 1'b1;
                  end
                  `SFID_OP_STATUS_WRITE:
                  begin
                     stat_wr_req_r <= 1'b1;
                     stat_wr_data_r <= d0_r;
                     wel_r <= 1'b0;
                     sw_en_r <= 1'b0;
                  end
                  // RULE_21 busy output on
                  `SFID_OP_BUSY_ON:
                  begin
                     bsy_en_r <= 1'b1;
                  end
                  // RULE_22 busy output off
                  `SFID_OP_BUSY_OFF:
                  begin
                     bsy_en_r <= 1'b0;
                  end
                  // RULE_10 sector erase
                  `SFID_OP_ERASE_4K:
                  begin
                     wel_r <= 1'b0;
                     erase_kind_r <= `SFID_ERASE_SECTOR;
                     erase_addr_r <= addr_r & ~m4k[AW-1:0];
                     erase_req_r <= ~(wp_en & ((addr_r | m4k[AW-1:0]) >= wp_base));
                  end
                  // RULE_11 32k block erase
                  `SFID_OP_ERASE_32K:
                  begin
                     wel_r <= 1'b0;
                     erase_kind_r <= `SFID_ERASE_BLK32;
                     erase_addr_r <= addr_r & ~m32k[AW-1:0];
                     erase_req_r <= ~(wp_en & ((addr_r | m32k[AW-1:0]) >= wp_base));
                  end
                  // RULE_12 64k block erase
                  `SFID_OP_ERASE_64K:
                  begin
                     wel_r <= 1'b0;
                     erase_kind_r <= `SFID_ERASE_BLK64;
                     erase_addr_r <= addr_r & ~m64k[AW-1:0];
                     erase_req_r <= ~(wp_en & ((addr_r | m64k[AW-1:0]) >= wp_base));
                  end
                  // RULE_13 chip erase
                  `SFID_OP_CHIP_ERASE_A, `SFID_OP_CHIP_ERASE_B:
                  begin
                     wel_r <= 1'b0;
                     erase_kind_r <= `SFID_ERASE_CHIP;
                     erase_addr_r <= {AW{1'b0}};
                     erase_req_r <= ~wp_en;
                  end
                  // RULE_14 byte program
                  `SFID_OP_BYTE_PROG:
                  begin
                     wel_r <= 1'b0;
                     // RULE_15 ignore protected target
                     if (!prot_here && wr_ok)
                     begin
                        pend_cnt_r <= 2'd1;
                        pend_addr_r <= addr_r;
                        pend_b1_r <= d0_r;
                     end
                  end
                  // RULE_18 even byte then odd
                  `SFID_OP_AUTO_INC_PROG:
                  begin
                     if (!(wp_en && aai_base >= wp_base) && wr_ok)
                     begin
                        pend_cnt_r <= 2'd2;
                        pend_addr_r <= aai_base;
                        pend_b0_r <= d0_r;
                        pend_b1_r <= d1_r;
                        addr_r <= aai_next;
                        // RULE_24 end at top address
                        aai_r <= (aai_next != {AW{1'b0}});
                        wel_r <= (aai_next != {AW{1'b0}});
                     end
                  end
                  default:
                  begin
                     state_r <= ST_IDLE;
                  end
               endcase
            end
         end
         else if (byte_done)
         begin
            bytecnt_r <= bytecnt_r + 1'b1;
            case (state_r)
               ST_IDLE:
               begin
                  cmd_r <= rx_byte;
                  bytecnt_r <= 2'd0;
                  need_r <= 2'd1;
                  state_r <= ST_IGN;
                  // RULE_25 drop unknown or unenabled
                  case (rx_byte)
                     // RULE_06 read, fast read and id reads
                     `SFID_OP_READ, `SFID_OP_FAST_READ,
                     `SFID_OP_ID_READ_A, `SFID_OP_ID_READ_B:
                     begin
                        if (!aai_r)
                        begin
                           state_r <= ST_ADDR;
                        end
                     end
                     // RULE_02 writes need latch set
                     `SFID_OP_ERASE_4K, `SFID_OP_ERASE_32K,
                     `SFID_OP_ERASE_64K, `SFID_OP_BYTE_PROG:
                     begin
                        if (wel_r && !aai_r)
                        begin
                           state_r <= ST_ADDR;
                        end
                     end
                     `SFID_OP_CHIP_ERASE_A, `SFID_OP_CHIP_ERASE_B:
                     begin
                        if (wel_r && !aai_r)
                        begin
                           state_r <= ST_DONE;
                        end
                     end
                     `SFID_OP_AUTO_INC_PROG:
                     begin
                        need_r <= 2'd2;
                        if (aai_r)
                        begin
                           state_r <= ST_DIN;
                        end
                        else if (wel_r)
                        begin
                           state_r <= ST_ADDR;
                        end
                     end
                     `SFID_OP_STATUS_WRITE:
                     begin
                        if ((wel_r || sw_en_r) && !aai_r)
                        begin
                           state_r <= ST_DIN;
                        end
                     end
                     // RULE_19 repeating status byte
                     `SFID_OP_STATUS_READ:
                     begin
                        state_r <= ST_OUT;
                        fetch_r <= 1'b1;
                     end
                     `SFID_OP_WRITE_DISABLE:
                     begin
                        state_r <= ST_DONE;
                     end
                     `SFID_OP_WRITE_ENABLE, `SFID_OP_STATUS_WRITE_EN,
                     `SFID_OP_BUSY_ON, `SFID_OP_BUSY_OFF:
                     begin
                        if (!aai_r)
                        begin
                           state_r <= ST_DONE;
                        end
                     end
                     default:
                     begin
                        state_r <= ST_IGN;
                     end
                  endcase
               end
               ST_ADDR:
               begin
                  addr_sh_r <= {addr_sh_r[7:0], rx_byte};
                  if (bytecnt_r == 2'd2)
                  begin
                     bytecnt_r <= 2'd0;
                     // RULE_23 upper bits dropped
                     addr_r <= addr24[AW-1:0];
                     mem_rd_addr_r <= addr24[AW-1:0];
                     if (cmd_r == `SFID_OP_FAST_READ)
                     begin
                        state_r <= ST_DUMMY;
                     end
                     else if (cmd_r == `SFID_OP_READ || cmd_r == `SFID_OP_ID_READ_A
                              || cmd_r == `SFID_OP_ID_READ_B)
                     begin
                        state_r <= ST_OUT;
                        fetch_r <= 1'b1;
                        mem_rd_en_r <= (cmd_r == `SFID_OP_READ);
                     end
                     else if (cmd_r == `SFID_OP_BYTE_PROG
                              || cmd_r == `SFID_OP_AUTO_INC_PROG)
                     begin
                        state_r <= ST_DIN;
                     end
                     else
                     begin
                        state_r <= ST_DONE;
                     end
                  end
               end
               // RULE_07 one dummy byte
               ST_DUMMY:
               begin
                  state_r <= ST_OUT;
                  fetch_r <= 1'b1;
                  mem_rd_en_r <= 1'b1;
                  mem_rd_addr_r <= addr_r;
               end
               ST_DIN:
               begin
                  d0_r <= (bytecnt_r == 2'd0) ? rx_byte : d0_r;
                  d1_r <= rx_byte;
                  if (bytecnt_r + 2'd1 == need_r)
                  begin
                     state_r <= ST_DONE;
                  end
               end
               ST_OUT:
               begin
                  fetch_r <= 1'b1;
                  mem_rd_en_r <= (cmd_r == `SFID_OP_READ || cmd_r == `SFID_OP_FAST_READ);
                  mem_rd_addr_r <= addr_r;
               end
               ST_DONE:
               begin
                  // RULE_14 extra byte cancels command
                  state_r <= ST_IGN;
               end
               default:
               begin
                  state_r <= ST_IGN;
               end
            endcase
         end
      end
   end
endmodule // sfid_decoder
`default_nettype wire

// [testbench/sfid_spi_host.sv]
// serial host model driving the flash link
`timescale 1ns/1ns
`default_nettype none
module sfid_spi_host (
   input wire logic mclk,
   output logic sck,
   output logic cs_n,
   output logic si,
   input wire logic so_o
);
   // clock idles low between frames
   initial {sck, cs_n, si} = 3'b010;
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic sel();
      tick(4);
      cs_n = 1'b0;
      tick(4);
   endtask
   task automatic desel();
      tick(4);
      cs_n = 1'b1;
      si = ~si;
      tick(4);
   endtask
   task automatic xfer(input logic [7:0] d, input int n, output logic [7:0] q);
      q = 8'h00;
      for (int i = 7; i > 7 - n; i--)
      begin
         si = d[i];
         tick(4);
         q[i] = so_o;
         sck = 1'b1;
         tick(4);
         sck = 1'b0;
      end
   endtask
endmodule // sfid_spi_host
`default_nettype wire

// [testbench/sfid_decoder_props.sv]
// port checker of the instruction decoder
`timescale 1ns/1ns
`default_nettype none
module sfid_decoder_props #(parameter AW = 21) (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic cs_n,
   input wire logic so_oe,
   input wire logic mem_rd_en_r,
   input wire logic erase_req_r,
   input wire logic [1:0] erase_kind_r,
   input wire logic [AW-1:0] erase_addr_r,
   input wire logic prog_valid,
   input wire logic prog_ready,
   input wire logic [AW-1:0] prog_addr,
   input wire logic [7:0] prog_data,
   input wire logic wel_r,
   input wire logic aai_r
);
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   sequence s_desel; cs_n [*8]; endsequence
   sequence s_stall; prog_valid && !prog_ready; endsequence
   a_desel_quiet: assert property (s_desel |-> !so_oe)
      else $error("so driven unselected");
   a_fetch_sel: assert property (mem_rd_en_r |-> !cs_n)
      else $error("fetch unselected");
   a_erase_wel: assert property (erase_req_r |-> $past(wel_r, 2))
      else $error("erase without enable");
   a_wel_drops: assert property (erase_req_r |-> ##[0:2] !wel_r)
      else $error("enable kept after erase");
   a_sector_align: assert property (erase_req_r && erase_kind_r == 2'h0 |->
      erase_addr_r[11:0] == 12'h000)
      else $error("sector not aligned");
   a_blk32_align: assert property (erase_req_r && erase_kind_r == 2'h1 |->
      erase_addr_r[14:0] == 15'h0000)
      else $error("block32 not aligned");
   a_blk64_align: assert property (erase_req_r && erase_kind_r == 2'h2 |->
      erase_addr_r[15:0] == 16'h0000)
      else $error("block64 not aligned");
   a_prog_hold: assert property (s_stall |=> prog_valid && $stable(prog_addr)
      && $stable(prog_data))
      else $error("word dropped");
   a_aai_entry: assert property ($rose(aai_r) |-> $past(wel_r))
      else $error("aai without wel");
endmodule // sfid_decoder_props
bind sfid_decoder sfid_decoder_props #(.AW(AW)) u_props (.*);
`default_nettype wire

// [testbench/tb_top.sv]
// self-checking bench of the instruction decoder
`timescale 1ns/1ns
`default_nettype none
`include "sfid_defs.vh"
module tb_top;
   logic mclk = 1'b0, sys_rst = 1'b1, busy_in = 1'b0, wp_en = 1'b0, prog_ready = 1'b0;
   logic [7:0] st = 8'h00, rx;
   logic [20:0] rd_a, er_a, p_a, ea, wpb = 21'h100000;
   logic [1:0] er_k, ek;
   logic [7:0] p_d;
   logic [31:0] lf = 32'd74312;
   logic [28:0] pq[$];
   logic [7:0] eop [6] = '{8'h20, 8'h52, 8'hD8, 8'h60, 8'hC7, 8'h20};
   logic [20:0] emk [3] = '{21'h000FFF, 21'h007FFF, 21'h00FFFF};
   wire sck, cs_n, si, so_o, er_req, pv, write_enable_latch, auto_increment_program, oe;
   int mismatches = 0, tests_run = 0, e_n = 0;
   function automatic logic [7:0] md(input logic [20:0] a);
      return a[7:0] ^ a[15:8] ^ {3'h0, a[20:16]};
   endfunction
   function automatic logic [31:0] nx(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   sfid_spi_host host (.mclk(mclk), .sck(sck), .cs_n(cs_n), .si(si), .so_o(so_o));
   sfid_decoder uut (.mclk(mclk), .sys_rst(sys_rst), .sck(sck), .cs_n(cs_n), .si(si),
      .so_o(so_o), .so_oe(oe), .busy_in(busy_in), .status_in(st), .wp_en(wp_en),
      .wp_base(wpb), .mem_rd_en_r(), .mem_rd_addr_r(rd_a), .mem_rd_data(md(rd_a)),
      .erase_req_r(er_req), .erase_kind_r(er_k), .erase_addr_r(er_a), .stat_wr_req_r(),
      .stat_wr_data_r(), .prog_valid(pv), .prog_ready(prog_ready), .prog_addr(p_a),
      .prog_data(p_d), .wel_r(write_enable_latch), .aai_r(auto_increment_program));
   always #5 mclk = ~mclk;
   always @(negedge mclk)
   begin
      if (er_req)
      begin
         e_n++;
         ek = er_k;
         ea = er_a;
      end
      if (pv && prog_ready) pq.push_back({p_a, p_d});
   end
   always @(posedge mclk)
   begin
      #1 lf = nx(lf);
      prog_ready = lf[2] | lf[7];
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         mismatches++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic sb(input logic [7:0] b);
      host.xfer(b, 8, rx);
   endtask
   task automatic sa(input logic [7:0] op, input logic [23:0] a);
      sb(op);
      sb(a[23:16]);
      sb(a[15:8]);
      sb(a[7:0]);
   endtask
   task automatic cmd(input logic [7:0] op);
      host.sel();
      sb(op);
      host.desel();
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial
   begin
      #500000;
      mismatches++;
      complete_run();
   end
   initial
   begin
      logic [23:0] a;
      logic [20:0] b;
      int n;
      repeat (20) @(posedge mclk);
      #1 sys_rst = 1'b0;
      host.tick(4);
      host.sel();
      host.xfer(8'h06, 7, rx);
      host.desel();
      chk(write_enable_latch, 0);
      for (int i = 0; i < 2; i++)
      begin
         a = i ? lf[23:0] : 24'hFFFFFE;
         b = a[20:0];
         host.sel();
         sa(i ? 8'h0B : 8'h03, a);
         if (i) sb(8'h00);
         repeat (3)
         begin
            sb(8'h00);
            chk(rx, md(b));
            b++;
         end
         host.desel();
      end
      for (int i = 0; i < 4; i++)
      begin
         host.sel();
         sa(i[1] ? 8'hAB : 8'h90, {23'h0, i[0]});
         repeat (2)
         begin
            sb(8'h00);
            chk(rx, i[0] ? `SFID_DEV_ID : `SFID_MAN_ID);
         end
         host.desel();
      end
      st = lf[7:0];
      busy_in = lf[8];
      cmd(8'h06);
      host.sel();
      sb(8'h05);
      repeat (2)
      begin
         sb(8'h00);
         chk(rx, {st[7], 1'b0, st[5:2], 1'b1, busy_in});
      end
      host.desel();
      busy_in = 1'b0;
      for (int i = 0; i < 6; i++)
      begin
         a = lf[23:0];
         n = e_n;
         if (i < 5) cmd(8'h06);
         host.sel();
         if (i == 3 || i == 4) sb(eop[i]);
         else sa(eop[i], a);
         host.desel();
         host.tick(8);
         chk(e_n, n + (i < 5));
         chk(write_enable_latch, 0);
         if (i < 3) chk(ea, a[20:0] & ~emk[i]);
         if (i < 5) chk(ek, i < 3 ? i : 3);
      end
      for (int i = 0; i < 2; i++)
      begin
         wp_en = i[0];
         a = {3'h0, i[0], lf[19:0]};
         b = {lf[31:24], 13'h0000};
         cmd(8'h06);
         host.sel();
         sa(8'h02, a);
         sb(b[20:13]);
         host.desel();
         host.tick(40);
         chk(pq.size(), 1 - i);
         if (i == 0) chk(pq.pop_front(), {a[20:0], b[20:13]});
      end
      wp_en = 1'b0;
      a = {4'h0, lf[19:1], 1'b1};
      b = {a[20:1], 1'b0};
      cmd(8'h70);
      cmd(8'h06);
      host.sel();
      sa(8'hAD, a);
      sb(8'h11);
      sb(8'h22);
      host.desel();
      host.tick(40);
      host.sel();
      chk({oe, so_o}, 3);
      sb(8'hAD);
      sb(8'h33);
      sb(8'h44);
      host.desel();
      host.tick(40);
      chk(pq.size(), 4);
      for (int k = 1; k < 5; k++)
      begin
         chk(pq.pop_front(), {b, 8'(8'h11 * k)});
         b++;
      end
      cmd(8'h04);
      cmd(8'h80);
      chk({auto_increment_program, write_enable_latch}, 0);
      complete_run();
   end
endmodule // tb_top
`default_nettype wire
